// ### hdl/ppc_pin_pad_control.v
// Overview of operation
// [RL1] pull-up enable bit one turns pin pull-up on, zero turns it off
// [RL2] pull-up forced off while pin is output, by direction or peripheral
// [RL3] pull-up forced off while an analog function owns the pin
// [RL4] pull-up bit four has no effect; that pin is output-only
// [RL5] slew bits five to zero enable output slew limiting per pin
// [RL6] slew setting ignored for pins configured as inputs
// [RL7] slew bit five has no effect; that pin is input-only
// [RL8] drive bit zero selects low drive, one selects high drive
// [RL9] drive selection applies only to output pins
// [RL10] drive bit five has no effect; that pin is input-only
// [RL11] after reset every pin is high-impedance input with pull-up off
// [RL12] direction bit zero makes input, one enables output driver
// [RL13] three 8-bit registers, bits 5:0 read/write, upper bits zero, reset zero
// [RL14] gated pull-up, slew and drive go out per pin to pad cells
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.vh"
module ppc_pin_pad_control (
   input wire clk, // 200 MHz bus clock
   input wire arst_n, // async reset, active low
   input wire [`PPC_ADDR_W-1:0] regAddr, // register word address
   input wire [7:0] regWrData, // write data
   input wire regWrStb, // write strobe
   input wire regRdStb, // read strobe
   input wire [`PPC_NPIN-1:0] pinDirectionBits, // port direction, 1 = output
   input wire [`PPC_NPIN-1:0] periphOutEn, // shared peripheral drives pin
   input wire [`PPC_NPIN-1:0] analogOwn, // analog function owns pin
   output reg [7:0] regRdData_r, // read data, cycle after strobe
   output reg [`PPC_NPIN-1:0] padPullupEn_r, // pull-up on per pin
   output reg [`PPC_NPIN-1:0] padSlewEn_r, // slew limiting per pin
   output reg [`PPC_NPIN-1:0] padHighDrive_r, // high drive per pin
   output reg [`PPC_NPIN-1:0] padOutEn_r // output driver enabled per pin
);

////////////////////////////////////////////////////////////////////////////////
// pin map: bits 3:0 are full two-way pins, bit 4 can only drive,
// bit 5 can only receive; pad controls trail register changes by one cycle
// all pad controls come from flops so the pads never see decode glitches
localparam [`PPC_NPIN-1:0] OUT_ONLY_MASK = `PPC_MASK_OUT_ONLY;
localparam [`PPC_NPIN-1:0] IN_ONLY_MASK = `PPC_MASK_IN_ONLY;

// stored settings
reg [`PPC_NPIN-1:0] pinPullupEnable_r;
reg [`PPC_NPIN-1:0] pinSlewRateEnable_r;
reg [`PPC_NPIN-1:0] pinDriveStrengthSelect_r;

// next values
reg [`PPC_NPIN-1:0] pinPullupEnable_nxt;
reg [`PPC_NPIN-1:0] pinSlewRateEnable_nxt;
reg [`PPC_NPIN-1:0] pinDriveStrengthSelect_nxt;
reg [7:0] regRdData_nxt;
reg [`PPC_NPIN-1:0] padPullupEn_nxt;
reg [`PPC_NPIN-1:0] padSlewEn_nxt;
reg [`PPC_NPIN-1:0] padHighDrive_nxt;
reg [`PPC_NPIN-1:0] padOutEn_nxt;

// pin roles and bus decode
reg [`PPC_NPIN-1:0] outEn;
reg [`PPC_NPIN-1:0] isOutput;
wire wrPullup;
wire wrSlew;
wire wrDrive;
wire rdPullup;
wire rdSlew;
wire rdDrive;

////////////////////////////////////////////////////////////////////////////////
// true when the bus address selects the given register
function regHit;
   input [`PPC_ADDR_W-1:0] addr;
   input [`PPC_ADDR_W-1:0] ofs;
   begin
      regHit = (addr == ofs);
   end
endfunction

// only bits 5:0 have storage; bits 7:6 of a write are dropped
function [`PPC_NPIN-1:0] padField;
   input [7:0] data;
   begin
      padField = data[`PPC_NPIN-1:0];
   end
endfunction

// bits 7:6 always read back as zero
function [7:0] readWord;
   input [`PPC_NPIN-1:0] field;
   begin
      readWord = {2'h0, field};
   end
endfunction

// analog ownership wins over any digital driver
function [`PPC_NPIN-1:0] driverOn;
   input [`PPC_NPIN-1:0] dir;
   input [`PPC_NPIN-1:0] periph;
   input [`PPC_NPIN-1:0] analog;
   integer i;
   begin
      for (i = 0; i < `PPC_NPIN; i = i + 1) begin
         driverOn[i] = (dir[i] | periph[i]) & ~analog[i];
      end
      driverOn = driverOn & ~IN_ONLY_MASK; // [RL12]
   end
endfunction

// output-only pin not owned by analog counts as output even with its direction bit clear
function [`PPC_NPIN-1:0] outputSide;
   input [`PPC_NPIN-1:0] drv;
   input [`PPC_NPIN-1:0] analog;
   integer i;
   begin
      for (i = 0; i < `PPC_NPIN; i = i + 1) begin
         outputSide[i] = drv[i] | (OUT_ONLY_MASK[i] & ~analog[i]);
      end
   end
endfunction

// pull-up only on a receiving pin that no analog function owns
function [`PPC_NPIN-1:0] pullGate;
   input [`PPC_NPIN-1:0] enable;
   input [`PPC_NPIN-1:0] isOut;
   input [`PPC_NPIN-1:0] analog;
   integer i;
   begin
      for (i = 0; i < `PPC_NPIN; i = i + 1) begin
         pullGate[i] = enable[i] & ~isOut[i] & ~analog[i]; // [RL1] [RL2] [RL3]
      end
      pullGate = pullGate & ~OUT_ONLY_MASK; // [RL4]
   end
endfunction

// shared by slew and drive: both act on output pins only
function [`PPC_NPIN-1:0] outGate;
   input [`PPC_NPIN-1:0] setting;
   input [`PPC_NPIN-1:0] isOut;
   integer i;
   begin
      for (i = 0; i < `PPC_NPIN; i = i + 1) begin
         outGate[i] = setting[i] & isOut[i]; // [RL6] [RL9]
      end
      outGate = outGate & ~IN_ONLY_MASK; // [RL7] [RL10]
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// a strobe on the unmapped address hits no register and is dropped
// write and read share one decode so the map cannot drift
assign wrPullup = regWrStb & regHit(regAddr, `PPC_OFS_PULLUP);
assign wrSlew = regWrStb & regHit(regAddr, `PPC_OFS_SLEW);
assign wrDrive = regWrStb & regHit(regAddr, `PPC_OFS_DRIVE);
assign rdPullup = regRdStb & regHit(regAddr, `PPC_OFS_PULLUP);
assign rdSlew = regRdStb & regHit(regAddr, `PPC_OFS_SLEW);
assign rdDrive = regRdStb & regHit(regAddr, `PPC_OFS_DRIVE);

////////////////////////////////////////////////////////////////////////////////
always @* begin
   if (wrPullup) begin
      pinPullupEnable_nxt = padField(regWrData); // [RL1] [RL13]
   end else begin
      pinPullupEnable_nxt = pinPullupEnable_r;
   end
end

always @* begin
   if (wrSlew) begin
      pinSlewRateEnable_nxt = padField(regWrData); // [RL5] [RL13]
   end else begin
      pinSlewRateEnable_nxt = pinSlewRateEnable_r;
   end
end

always @* begin
   if (wrDrive) begin
      pinDriveStrengthSelect_nxt = padField(regWrData); // [RL8] [RL13]
   end else begin
      pinDriveStrengthSelect_nxt = pinDriveStrengthSelect_r;
   end
end

////////////////////////////////////////////////////////////////////////////////
// settings clear to zero: every pin starts as a floating input
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      pinPullupEnable_r <= `PPC_RST_PULLUP; // [RL13]
   end else begin
      pinPullupEnable_r <= pinPullupEnable_nxt;
   end
end

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      pinSlewRateEnable_r <= `PPC_RST_SLEW; // [RL13]
   end else begin
      pinSlewRateEnable_r <= pinSlewRateEnable_nxt;
   end
end

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      pinDriveStrengthSelect_r <= `PPC_RST_DRIVE; // [RL13]
   end else begin
      pinDriveStrengthSelect_r <= pinDriveStrengthSelect_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////
// read data is a one-cycle pulse; idle cycles return zero
always @* begin
   regRdData_nxt = 8'h00;
   case ({rdDrive, rdSlew, rdPullup})
      3'h1: begin
         regRdData_nxt = readWord(pinPullupEnable_r); // [RL13]
      end
      3'h2: begin
         regRdData_nxt = readWord(pinSlewRateEnable_r);
      end
      3'h4: begin
         regRdData_nxt = readWord(pinDriveStrengthSelect_r);
      end
      default: begin
         regRdData_nxt = 8'h00;
      end
   endcase
end

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      regRdData_r <= 8'h00;
   end else begin
      regRdData_r <= regRdData_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////
always @* begin
   outEn = driverOn(pinDirectionBits, periphOutEn, analogOwn); // [RL12]
end

always @* begin
   isOutput = outputSide(outEn, analogOwn);
end

////////////////////////////////////////////////////////////////////////////////
// gating follows direction and ownership live, not at write time
always @* begin
   padOutEn_nxt = outEn; // [RL12]
end

// pull-up gated by direction, peripheral and analog ownership
always @* begin
   padPullupEn_nxt = pullGate(pinPullupEnable_r, isOutput, analogOwn); // [RL2]
end

// slew limiting only on output-side pins: a driving pin, or bit 4 unless analog owns it
always @* begin
   padSlewEn_nxt = outGate(pinSlewRateEnable_r, isOutput); // [RL5] [RL6]
end

// drive strength only on output-side pins: a driving pin, or bit 4 unless analog owns it
always @* begin
   padHighDrive_nxt = outGate(pinDriveStrengthSelect_r, isOutput); // [RL8] [RL9]
end

////////////////////////////////////////////////////////////////////////////////
// pad controls are registered: one cycle of lag after a config change
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      padOutEn_r <= `PPC_RST_DIR; // [RL11]
   end else begin
      padOutEn_r <= padOutEn_nxt; // [RL14]
   end
end

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      padPullupEn_r <= `PPC_RST_PULLUP; // [RL11]
   end else begin
      padPullupEn_r <= padPullupEn_nxt; // [RL14]
   end
end

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      padSlewEn_r <= `PPC_RST_SLEW; // [RL11]
   end else begin
      padSlewEn_r <= padSlewEn_nxt; // [RL14]
   end
end

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      padHighDrive_r <= `PPC_RST_DRIVE; // [RL11]
   end else begin
      padHighDrive_r <= padHighDrive_nxt; // [RL14]
   end
end

endmodule
`default_nettype wire

// ### hdl/ppc_defines.vh
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH
`define PPC_ADDR_W 2
`define PPC_NPIN 6
`define PPC_OFS_PULLUP 2'h0
`define PPC_OFS_SLEW 2'h1
`define PPC_OFS_DRIVE 2'h2
`define PPC_RST_PULLUP 6'h00
`define PPC_RST_SLEW 6'h00
`define PPC_RST_DRIVE 6'h00
`define PPC_RST_DIR 6'h00
`define PPC_BIT_OUT_ONLY 4
`define PPC_BIT_IN_ONLY 5
`define PPC_MASK_OUT_ONLY 6'h10
`define PPC_MASK_IN_ONLY 6'h20
`endif

// ### tb/ppc_pad_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_pad_properties (
   input wire clk, // bus clock
   input wire arst_n, // async reset, active low
   input wire regRdStb, // read strobe
   input wire [7:0] regRdData_r, // read data
   input wire [5:0] pinDirectionBits, // direction bits
   input wire [5:0] periphOutEn, // peripheral drives pin
   input wire [5:0] analogOwn, // analog owns pin
   input wire [5:0] padPullupEn_r, // pull-up to pad
   input wire [5:0] padSlewEn_r, // slew limit to pad
   input wire [5:0] padHighDrive_r, // high drive to pad
   input wire [5:0] padOutEn_r // driver enable to pad
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!arst_n);
a_pull_out: assert property ((padPullupEn_r & padOutEn_r) == 6'h00)
   else $error("pull-up on while driver on");
a_pull_ana: assert property ((padPullupEn_r & $past(analogOwn)) == 6'h00)
   else $error("pull-up on analog pin");
a_pull_four: assert property (!padPullupEn_r[4])
   else $error("pull-up on output-only pin");
a_in_only: assert property (!padSlewEn_r[5] && !padHighDrive_r[5])
   else $error("slew or drive on input-only pin");
a_slew_in: assert property ((padSlewEn_r[3:0] & ~padOutEn_r[3:0]) == 4'h0)
   else $error("slew on input pin");
a_drive_in: assert property ((padHighDrive_r[3:0] & ~padOutEn_r[3:0]) == 4'h0)
   else $error("high drive on input pin");
a_dir_out: assert property ($past(arst_n) |-> padOutEn_r ==
   ($past((pinDirectionBits | periphOutEn) & ~analogOwn) & 6'h1f))
   else $error("driver enable wrong");
a_read_idle: assert property (!$past(regRdStb) |-> regRdData_r == 8'h00)
   else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ### tb/ppc_pad_pins.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_pad_pins (
   input wire [5:0] pu, // pull-up enables from the pads
   input wire [5:0] oe, // driver enables from the pads
   output wire [5:0] lvl // level of an undriven pin
);
// board pulls floating pins low, so only the pull-up lifts them
assign lvl = pu & ~oe;
endmodule
`default_nettype wire

// ### tb/ppc_pin_pad_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_pin_pad_control_tb;
reg clk = 1'h0;
reg arst_n = 1'h0;
reg ws = 1'h0;
reg rs = 1'h0;
reg [1:0] a = 2'h0;
reg [7:0] wd = 8'h00;
reg [7:0] v;
reg [5:0] dir = 6'h00;
reg [5:0] per = 6'h00;
reg [5:0] an = 6'h00;
reg [5:0] o;
reg [5:0] s;
reg [5:0] rg [0:3];
wire [7:0] rd;
wire [5:0] pu;
wire [5:0] sl;
wire [5:0] hd;
wire [5:0] oe;
wire [5:0] lv;
int n_fail = 0;
int cmp_count = 0;
int k;
always #2.5 clk = ~clk;
ppc_pin_pad_control dut (
   .clk(clk),
   .arst_n(arst_n),
   .regAddr(a),
   .regWrData(wd),
   .regWrStb(ws),
   .regRdStb(rs),
   .pinDirectionBits(dir),
   .periphOutEn(per),
   .analogOwn(an),
   .regRdData_r(rd),
   .padPullupEn_r(pu),
   .padSlewEn_r(sl),
   .padHighDrive_r(hd),
   .padOutEn_r(oe)
);
ppc_pad_pins far (
   .pu(pu),
   .oe(oe),
   .lvl(lv)
);
task chk(input string n, input reg [7:0] e, input reg [7:0] g);
   cmp_count++;
   if (e !== g) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
   end
endtask
// expected pads from the rules, one cycle after the inputs settled
task checkPads;
   o = (dir | per) & ~an & 6'h1f;
   s = o | (6'h10 & ~an);
   chk("oe", o, oe);
   chk("pu", rg[0] & ~s & ~an & 6'h2f, pu);
   chk("sl", rg[1] & s & 6'h1f, sl);
   chk("hd", rg[2] & s & 6'h1f, hd);
   chk("lv", rg[0] & ~s & ~an & 6'h2f, lv);
endtask
task final_report;
   if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
   end else begin
      $display("Simulation failed");
   end
   $finish;
endtask
initial begin
   void'($urandom(32'hb832));
   for (k = 0; k < 4; k++) begin
      rg[k] = 6'h00;
   end
   repeat (4) @(posedge clk);
   #1;
   chk("rd", 8'h00, rd);
   checkPads;
   @(posedge clk);
   arst_n <= 1'h1;
   for (k = 0; k < 80; k++) begin
      @(posedge clk);
      v = $urandom;
      a <= k[1:0];
      wd <= v;
      ws <= 1'h1;
      if (k % 4 != 3) begin
         rg[k % 4] = v[5:0];
      end
      @(posedge clk);
      ws <= 1'h0;
      rs <= 1'h1;
      {dir, per, an} <= 18'($urandom);
      @(posedge clk);
      rs <= 1'h0;
      #1;
      chk("rd", {2'h0, rg[k % 4]}, rd);
      checkPads;
   end
   // reset in mid-run with live settings and driven pins
   @(posedge clk);
   arst_n <= 1'h0;
   #1;
   chk("oe", 8'h00, oe);
   chk("pu", 8'h00, pu);
   chk("sl", 8'h00, sl);
   chk("hd", 8'h00, hd);
   for (k = 0; k < 4; k++) begin
      rg[k] = 6'h00;
   end
   repeat (2) @(posedge clk);
   arst_n <= 1'h1;
   for (k = 0; k < 4; k++) begin
      @(posedge clk);
      a <= k[1:0];
      rs <= 1'h1;
      @(posedge clk);
      rs <= 1'h0;
      #1;
      chk("rd", {2'h0, rg[k]}, rd);
   end
   checkPads;
   final_report;
end
endmodule
bind ppc_pin_pad_control ppc_pad_properties chk_i (
   .clk(clk),
   .arst_n(arst_n),
   .regRdStb(regRdStb),
   .regRdData_r(regRdData_r),
   .pinDirectionBits(pinDirectionBits),
   .periphOutEn(periphOutEn),
   .analogOwn(analogOwn),
   .padPullupEn_r(padPullupEn_r),
   .padSlewEn_r(padSlewEn_r),
   .padHighDrive_r(padHighDrive_r),
   .padOutEn_r(padOutEn_r)
);
`default_nettype wire
